// *** rtl/mvp_postproc.sv ***
`timescale 1ns/1ps
module mvp_postproc import mvp_pkg::*; #(
  parameter int NP = NPTS_MAX,
  parameter int NA = N_ALARMS
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // apb slave
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // measurement front end
  input  wire logic          meas_valid,
  input  wire logic [31:0]   meas_value,
  input  wire logic          meas_overflow,
  output logic               meas_ready,
  // relays, display, interrupt
  output logic [NA-1:0]      alarm_out,
  output logic [31:0]        disp_value,
  output logic [4:0]         disp_dots,
  output logic               disp_overflow,
  output logic               irq
);

  if (NP < 2 || NP > NPTS_MAX || NA < 1 || NA > N_ALARMS)
    $error("mvp_postproc: NP must be 2..21 and NA 1..4");

  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_DIV} mvp_fsm_t;

  typedef struct packed {
    mvp_fsm_t             st;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic                 charact_enable;
    logic [2:0]           fmt;
    logic [1:0]           tmode;
    logic [4:0]           npts;
    logic [NP-1:0][31:0]  meas_point;
    logic [NP-1:0][31:0]  disp_point;
    logic [NA-1:0][2:0]   alarm_mode_sel;
    logic [NA-1:0][31:0]  alarm_low_threshold;
    logic [NA-1:0][31:0]  alarm_high_threshold;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [31:0]          x;
    logic                 ovf;
    logic [4:0]           seg;
    logic [31:0]          result;
    logic [NA-1:0]        alarm;
    logic [31:0]          disp_value;
    logic [4:0]           disp_dots;
    logic                 inval;
  } mvp_state_t;

  // factory settings, also the reset image
  function automatic mvp_state_t restore(mvp_state_t s);
    mvp_state_t r;
    r = s;
    r.charact_enable = 1'b0;
    r.npts = RST_NPTS;
    for (int i = 0; i < NP; i++) begin
      r.meas_point[i] = 32'(i) * RST_PT_STEP;
      r.disp_point[i] = 32'(i) * RST_PT_STEP;
    end
    for (int a = 0; a < NA; a++) begin
      r.alarm_mode_sel[a] = AM_HOFF;
      r.alarm_low_threshold[a] = RST_LOW;
      r.alarm_high_threshold[a] = RST_HIGH;
    end
    return r;
  endfunction

  localparam mvp_state_t RST_S = restore(mvp_state_t'(0));

  // entered values clamp to the allowed range
  function automatic logic [31:0] clampv(logic [31:0] v);
    if ($signed(v) > VAL_MAX) return 32'(VAL_MAX);
    if ($signed(v) < VAL_MIN) return 32'(VAL_MIN);
    return v;
  endfunction

  function automatic logic [31:0] pow10(int k);
    case (k)
      0:       return 32'h00000001;
      1:       return 32'h0000000A;
      2:       return 32'h00000064;
      3:       return 32'h000003E8;
      default: return 32'h00002710;
    endcase
  endfunction

  // value shown with d decimals of the four carried
  function automatic logic [31:0] scale(logic [31:0] v, int d);
    return 32'($signed(v) / $signed(pow10(FRAC_DIGITS - d)));
  endfunction

  // display word and decimal point mask
  function automatic logic [36:0] fmt_disp(logic [31:0] v, logic [2:0] f,
                                           logic [1:0] tm);
    logic [31:0] sec;
    logic [31:0] h;
    logic [31:0] m;
    logic [31:0] ss;
    logic [31:0] q;
    logic [4:0]  dots;
    int          d;
    sec = v[31] ? '0 : v;
    if (tm == TM_CLOCK) sec = 32'(sec % SEC_PER_DAY);
    h = 32'(sec / SEC_PER_HOUR);
    m = 32'((sec % SEC_PER_HOUR) / SEC_PER_MIN);
    ss = 32'(sec % SEC_PER_MIN);
    q = '0;
    dots = '0;
    d = 0;
    if (tm == TM_CLOCK) begin
      q = 32'(h * pow10(2) + m);
      dots = DOTS_HM;
    end else if (tm == TM_WORK) begin
      if (h < WT_SHORT_H) begin
        q = 32'(h * pow10(4) + m * pow10(2) + ss);
        dots = DOTS_HMS;
      end else if (h < WT_MID_H) begin
        q = 32'(h * pow10(2) + m);
        dots = DOTS_HM;
      end else begin
        q = h;
      end
    end else begin
      if (f == FMT_AUTO) begin
        // largest decimal count whose digits still fit
        for (int k = 0; k <= FRAC_DIGITS; k++) begin
          if ($signed(scale(v, k)) <= DISP_MAX &&
              $signed(scale(v, k)) >= DISP_MIN) d = k;
        end
      end else begin
        d = int'(f);
      end
      q = scale(v, d);
      dots = (d == 0) ? 5'h00 : 5'(5'h01 << d);
    end
    return {dots, q};
  endfunction

  // threshold alarm with memory for the hysteresis modes
  function automatic logic alarm_next(logic [2:0] md, logic [31:0] v,
                                      logic [31:0] lo, logic [31:0] hi,
                                      logic prev);
    logic inside_band;
    inside_band = $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi);
    if (md == AM_HON) return 1'b1;
    if (md == AM_HOFF) return 1'b0;
    if ($signed(lo) > $signed(hi)) return 1'b0;
    case (md)
      AM_NON: begin
        if ($signed(v) > $signed(hi)) return 1'b1;
        if ($signed(v) < $signed(lo)) return 1'b0;
        return prev;
      end
      AM_NOFF: begin
        if ($signed(v) < $signed(lo)) return 1'b1;
        if ($signed(v) > $signed(hi)) return 1'b0;
        return prev;
      end
      AM_ON:   return inside_band;
      default: return !inside_band;
    endcase
  endfunction

  // points must rise strictly over the configured count
  function automatic logic points_bad(mvp_state_t s);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < NP - 1; i++) begin
      if (5'(i) < s.npts - 5'h01 &&
          $signed(s.meas_point[i+1]) <= $signed(s.meas_point[i]))
        bad = 1'b1;
    end
    return bad;
  endfunction

  function automatic logic addr_ok(logic [11:0] a);
    logic ok;
    ok = a <= OFS_DISP_DOTS;
    if (a[11:4] == OFS_ALM_MODE[11:4] || a[11:4] == OFS_ALM_LOW[11:4] ||
        a[11:4] == OFS_ALM_HIGH[11:4])
      ok = int'(a[3:2]) < NA;
    if (a[11:7] == OFS_MEAS_PT[11:7] || a[11:7] == OFS_DISP_PT[11:7])
      ok = int'(a[6:2]) < NP;
    return ok && a[1:0] == 2'h0;
  endfunction

  mvp_state_t       s_ff, nxt_s;
  logic             div_start;
  logic             div_done;
  logic [63:0]      div_num;
  logic [31:0]      div_den;
  logic [63:0]      div_quot;
  logic             bad;
  logic             wr;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [31:0]      rd;
  logic [4:0]       seg1;
  logic [31:0]      np_v;

  // segment operands; slope division done by the shared divider
  always_comb begin
    logic [63:0] dx;
    logic [63:0] dy;
    seg1 = 5'(s_ff.seg + 5'h01);
    dx = 64'($signed(s_ff.x)) - 64'($signed(s_ff.meas_point[s_ff.seg]));
    dy = 64'($signed(s_ff.disp_point[seg1])) -
         64'($signed(s_ff.disp_point[s_ff.seg]));
    div_num = 64'(dx * dy);
    div_den = 32'(s_ff.meas_point[seg1] - s_ff.meas_point[s_ff.seg]);
  end

  mvp_div #(
    .NW (DIV_W),
    .DW (32)
  ) u_div (
    .clk   (clk),
    .rstn  (rstn),
    .start (div_start),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quot  (div_quot)
  );

  // register read mux
  always_comb begin
    rd = '0;
    if (paddr == OFS_CTRL) begin
      rd[CTRL_CHAR_EN] = s_ff.charact_enable;
      rd[CTRL_FMT_LSB +: 3] = s_ff.fmt;
      rd[CTRL_TMODE_LSB +: 2] = s_ff.tmode;
      rd[CTRL_NPTS_LSB +: 5] = s_ff.npts;
    end else if (paddr == OFS_STATUS) begin
      rd[STAT_INVAL] = s_ff.inval;
      rd[STAT_BUSY] = s_ff.st != S_IDLE;
      rd[STAT_ALM_LSB +: NA] = s_ff.alarm;
      rd[STAT_OVF] = s_ff.ovf;
    end else if (paddr == OFS_IRQ_STAT) begin
      rd[IRQ_W-1:0] = s_ff.irq_stat;
    end else if (paddr == OFS_IRQ_MASK) begin
      rd[IRQ_W-1:0] = s_ff.irq_mask;
    end else if (paddr == OFS_RESULT) begin
      rd = s_ff.result;
    end else if (paddr == OFS_DISP_VAL) begin
      rd = s_ff.disp_value;
    end else if (paddr == OFS_DISP_DOTS) begin
      rd[4:0] = s_ff.disp_dots;
    end else if (paddr[11:4] == OFS_ALM_MODE[11:4]) begin
      rd[2:0] = s_ff.alarm_mode_sel[paddr[3:2]];
    end else if (paddr[11:4] == OFS_ALM_LOW[11:4]) begin
      rd = s_ff.alarm_low_threshold[paddr[3:2]];
    end else if (paddr[11:4] == OFS_ALM_HIGH[11:4]) begin
      rd = s_ff.alarm_high_threshold[paddr[3:2]];
    end else if (paddr[11:7] == OFS_MEAS_PT[11:7]) begin
      rd = s_ff.meas_point[paddr[6:2]];
    end else if (paddr[11:7] == OFS_DISP_PT[11:7]) begin
      rd = s_ff.disp_point[paddr[6:2]];
    end
  end

  // next state of everything
  always_comb begin
    nxt_s = s_ff;
    div_start = 1'b0;
    ev = '0;
    clr = '0;
    np_v = 32'(pwdata[CTRL_NPTS_LSB +: 5]);
    bad = points_bad(s_ff);
    wr = psel && penable && pwrite && addr_ok(paddr);
    // read data and error latched in the setup cycle
    if (psel && !penable) begin
      nxt_s.prdata = (addr_ok(paddr) && !pwrite) ? rd : '0;
      nxt_s.pslverr = !addr_ok(paddr);
    end
    if (wr) begin
      if (paddr == OFS_CTRL) begin
        nxt_s.charact_enable = pwdata[CTRL_CHAR_EN];
        nxt_s.fmt = (pwdata[CTRL_FMT_LSB +: 3] > FMT_AUTO) ? FMT_AUTO
                    : pwdata[CTRL_FMT_LSB +: 3];
        nxt_s.tmode = (pwdata[CTRL_TMODE_LSB +: 2] > TM_WORK) ? TM_WORK
                      : pwdata[CTRL_TMODE_LSB +: 2];
        if (np_v < 32'(RST_NPTS)) nxt_s.npts = RST_NPTS;
        else if (np_v > 32'(NP)) nxt_s.npts = 5'(NP);
        else nxt_s.npts = pwdata[CTRL_NPTS_LSB +: 5];
        if (pwdata[CTRL_RESTORE]) nxt_s = restore(nxt_s);
      end else if (paddr == OFS_IRQ_STAT) begin
        clr = pwdata[IRQ_W-1:0];
      end else if (paddr == OFS_IRQ_MASK) begin
        nxt_s.irq_mask = pwdata[IRQ_W-1:0];
      end else if (paddr[11:4] == OFS_ALM_MODE[11:4]) begin
        nxt_s.alarm_mode_sel[paddr[3:2]] =
          (pwdata[2:0] > AM_HOFF) ? AM_HOFF : pwdata[2:0];
      end else if (paddr[11:4] == OFS_ALM_LOW[11:4]) begin
        nxt_s.alarm_low_threshold[paddr[3:2]] = clampv(pwdata);
      end else if (paddr[11:4] == OFS_ALM_HIGH[11:4]) begin
        nxt_s.alarm_high_threshold[paddr[3:2]] = clampv(pwdata);
      end else if (paddr[11:7] == OFS_MEAS_PT[11:7]) begin
        nxt_s.meas_point[paddr[6:2]] = clampv(pwdata);
      end else if (paddr[11:7] == OFS_DISP_PT[11:7]) begin
        nxt_s.disp_point[paddr[6:2]] = clampv(pwdata);
      end
    end
    // measurement path; a new value waits while busy
    unique case (s_ff.st)
      S_IDLE: begin
        if (meas_valid) begin
          nxt_s.x = meas_value;
          nxt_s.ovf = meas_overflow;
          nxt_s.seg = '0;
          if (s_ff.tmode != TM_NORMAL || !s_ff.charact_enable || bad) begin
            nxt_s.result = meas_value;
            ev[IRQ_RESULT] = 1'b1;
          end else begin
            nxt_s.st = S_SCAN;
          end
        end
      end
      S_SCAN: begin
        // first segment also covers values below it, last above it
        if (s_ff.seg >= s_ff.npts - 5'h02 ||
            $signed(s_ff.x) < $signed(s_ff.meas_point[seg1])) begin
          div_start = 1'b1;
          nxt_s.st = S_DIV;
        end else begin
          nxt_s.seg = seg1;
        end
      end
      S_DIV: begin
        if (div_done) begin
          nxt_s.result = 32'(s_ff.disp_point[s_ff.seg] + div_quot[31:0]);
          nxt_s.st = S_IDLE;
          ev[IRQ_RESULT] = 1'b1;
        end
      end
      default: nxt_s.st = S_IDLE;
    endcase
    // alarms track the result; overflow does not stop them
    for (int a = 0; a < NA; a++) begin
      nxt_s.alarm[a] = alarm_next(s_ff.alarm_mode_sel[a], s_ff.result,
                                  s_ff.alarm_low_threshold[a],
                                  s_ff.alarm_high_threshold[a],
                                  s_ff.alarm[a]);
      ev[IRQ_ALARM_LSB + a] = nxt_s.alarm[a] != s_ff.alarm[a];
    end
    {nxt_s.disp_dots, nxt_s.disp_value} =
      fmt_disp(s_ff.result, s_ff.fmt, s_ff.tmode);
    nxt_s.inval = bad;
    ev[IRQ_INVAL] = bad && !s_ff.inval;
    // a set in the same cycle as its clear wins
    nxt_s.irq_stat = (s_ff.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= RST_S;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs; pready is constant, the slave never stalls
  assign prdata        = s_ff.prdata;
  assign pready        = 1'b1;
  assign pslverr       = s_ff.pslverr;
  assign meas_ready    = s_ff.st == S_IDLE;
  assign alarm_out     = s_ff.alarm;
  assign disp_value    = s_ff.disp_value;
  assign disp_dots     = s_ff.disp_dots;
  assign disp_overflow = s_ff.ovf;
  assign irq           = |(s_ff.irq_stat & s_ff.irq_mask);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  for (genvar g = 0; g < NA; g++) begin : g_chk
    a_forced_on: assert property (
      s_ff.alarm_mode_sel[g] == AM_HON |=> alarm_out[g])
      else $error("forced-on alarm not active");
    a_forced_off: assert property (
      s_ff.alarm_mode_sel[g] == AM_HOFF |=> !alarm_out[g])
      else $error("forced-off alarm active");
    a_low_above_high: assert property (
      s_ff.alarm_mode_sel[g] < AM_HON &&
      $signed(s_ff.alarm_low_threshold[g]) >
      $signed(s_ff.alarm_high_threshold[g]) |=> !alarm_out[g])
      else $error("alarm on with low above high");
    a_thr_clamped: assert property (
      $signed(s_ff.alarm_low_threshold[g]) <= VAL_MAX &&
      $signed(s_ff.alarm_low_threshold[g]) >= VAL_MIN)
      else $error("threshold out of range");
  end

  a_bypass_invalid: assert property (
    s_ff.st == S_IDLE && meas_valid && bad
    |=> s_ff.result == $past(meas_value) && s_ff.inval)
    else $error("invalid characteristic not bypassed");
  a_npts_range: assert property (
    s_ff.npts >= RST_NPTS && 32'(s_ff.npts) <= 32'(NP))
    else $error("point count out of range");
  a_div_bound: assert property (
    div_start |=> s_ff.st == S_DIV [*8] ##[57:60] s_ff.st == S_IDLE)
    else $error("interpolation did not finish in time");
  a_restore_def: assert property (
    wr && paddr == OFS_CTRL && pwdata[CTRL_RESTORE]
    |=> s_ff.alarm_mode_sel[0] == AM_HOFF &&
        s_ff.alarm_low_threshold[0] == RST_LOW &&
        s_ff.alarm_high_threshold[0] == RST_HIGH)
    else $error("restore did not load defaults");
  a_clock_dots: assert property (
    s_ff.tmode == TM_CLOCK && $stable(s_ff.tmode) |=> disp_dots == DOTS_HM)
    else $error("clock mode point wrong");
  a_inval_irq: assert property (
    bad && !s_ff.inval |=> s_ff.irq_stat[IRQ_INVAL])
    else $error("invalid points did not raise status");

  c_interp: cover property (s_ff.st == S_DIV && div_done && s_ff.seg != 0);
  c_alarm_rise: cover property ($rose(alarm_out[0]));
  c_restore: cover property (wr && paddr == OFS_CTRL &&
                             pwdata[CTRL_RESTORE]);
  c_invalid: cover property ($rose(s_ff.inval));

endmodule

// *** inc/mvp_pkg.sv ***
package mvp_pkg;

  // geometry: 21 points give 20 segments
  localparam int NPTS_MAX    = 21;
  localparam int N_ALARMS    = 4;
  localparam int DIV_W       = 64;
  localparam int FRAC_DIGITS = 4;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h00C;
  localparam logic [11:0] OFS_RESULT    = 12'h010;
  localparam logic [11:0] OFS_DISP_VAL  = 12'h014;
  localparam logic [11:0] OFS_DISP_DOTS = 12'h018;
  localparam logic [11:0] OFS_ALM_MODE  = 12'h020;
  localparam logic [11:0] OFS_ALM_LOW   = 12'h030;
  localparam logic [11:0] OFS_ALM_HIGH  = 12'h040;
  localparam logic [11:0] OFS_MEAS_PT   = 12'h080;
  localparam logic [11:0] OFS_DISP_PT   = 12'h100;

  // control / status field positions
  localparam int CTRL_CHAR_EN   = 0;
  localparam int CTRL_RESTORE   = 1;
  localparam int CTRL_FMT_LSB   = 2;
  localparam int CTRL_TMODE_LSB = 5;
  localparam int CTRL_NPTS_LSB  = 8;
  localparam int STAT_INVAL     = 0;
  localparam int STAT_BUSY      = 1;
  localparam int STAT_ALM_LSB   = 2;
  localparam int STAT_OVF       = 6;

  // interrupt status bits
  localparam int IRQ_W         = 6;
  localparam int IRQ_INVAL     = 0;
  localparam int IRQ_RESULT    = 1;
  localparam int IRQ_ALARM_LSB = 2;

  // alarm mode codes
  localparam logic [2:0] AM_NON  = 3'h0;
  localparam logic [2:0] AM_NOFF = 3'h1;
  localparam logic [2:0] AM_ON   = 3'h2;
  localparam logic [2:0] AM_OFF  = 3'h3;
  localparam logic [2:0] AM_HON  = 3'h4;
  localparam logic [2:0] AM_HOFF = 3'h5;

  // time modes and display formats
  localparam logic [1:0] TM_NORMAL = 2'h0;
  localparam logic [1:0] TM_CLOCK  = 2'h1;
  localparam logic [1:0] TM_WORK   = 2'h2;
  localparam logic [2:0] FMT_AUTO  = 3'h4;
  localparam logic [4:0] DOTS_HMS  = 5'h14;
  localparam logic [4:0] DOTS_HM   = 5'h04;

  // limits and time figures
  localparam int VAL_MIN      = -199990000;
  localparam int VAL_MAX      = 999990000;
  localparam int DISP_MIN     = -19999;
  localparam int DISP_MAX     = 99999;
  localparam int SEC_PER_MIN  = 60;
  localparam int SEC_PER_HOUR = 3600;
  localparam int SEC_PER_DAY  = 86400;
  localparam int WT_SHORT_H   = 10;
  localparam int WT_MID_H     = 1000;

  // factory values
  localparam logic [31:0] RST_LOW     = 32'h000003E8;
  localparam logic [31:0] RST_HIGH    = 32'h000007D0;
  localparam logic [31:0] RST_PT_STEP = 32'h00000064;
  localparam logic [4:0]  RST_NPTS    = 5'h02;

endpackage

// *** rtl/mvp_div.sv ***
`timescale 1ns/1ps
module mvp_div import mvp_pkg::*; #(
  parameter int NW = DIV_W,
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // answer
  output logic               done,
  output logic [NW-1:0]      quot
);
  localparam int CW = $clog2(NW);

  if (NW < DW || DW < 2) $error("mvp_div: NW must be at least DW");

  typedef struct packed {
    logic          busy;
    logic          done;
    logic          neg;
    logic [CW-1:0] cnt;
    logic [DW:0]   rem;
    logic [DW-1:0] den;
    logic [NW-1:0] q;
  } mvp_div_t;

  mvp_div_t s_ff, nxt_s;

  // restoring division on magnitudes, one quotient bit per cycle
  always_comb begin
    logic [DW:0]   r;
    logic [NW-1:0] nq;
    logic          qb;
    r = '0;
    nq = '0;
    qb = 1'b0;
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (start) begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt = '0;
      nxt_s.rem = '0;
      nxt_s.q = num[NW-1] ? NW'(-num) : num;
      nxt_s.den = den[DW-1] ? DW'(-den) : den;
      nxt_s.neg = num[NW-1] ^ den[DW-1];
    end else if (s_ff.busy) begin
      r = {s_ff.rem[DW-1:0], s_ff.q[NW-1]};
      qb = r >= {1'b0, s_ff.den};
      if (qb) r = r - {1'b0, s_ff.den};
      nq = {s_ff.q[NW-2:0], qb};
      nxt_s.rem = r;
      nxt_s.q = nq;
      nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
      if (s_ff.cnt == CW'(NW - 1)) begin
        // sign fixed here so quot comes straight from a flop
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
        nxt_s.q = s_ff.neg ? NW'(-nq) : nq;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
  assign quot = s_ff.q;

endmodule

// *** tb/mvp_fe_model.sv ***
`timescale 1ns/1ps
// front end stand-in: offers a value and holds it until taken
module mvp_fe_model (
  // clock
  input  wire logic   clk,
  // handshake toward the block
  input  wire logic   meas_ready,
  output logic        meas_valid,
  output logic [31:0] meas_value,
  output logic        meas_overflow
);
  initial begin
    meas_valid    = 1'b0;
    meas_value    = 32'h00000000;
    meas_overflow = 1'b0;
  end

  // value and qualifier stay put until the taking edge
  task automatic send(input logic [31:0] v, input logic ovf);
    @(posedge clk);
    meas_valid    <= 1'b1;
    meas_value    <= v;
    meas_overflow <= ovf;
    @(posedge clk);
    while (meas_ready !== 1'b1) @(posedge clk);
    meas_valid    <= 1'b0;
    // released lines show junk so a stale value cannot pass
    meas_value    <= ~v;
    meas_overflow <= ~ovf;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb import mvp_pkg::*;;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mv, dv;
  logic        mval, movf, mrdy, dovf, irq;
  logic [3:0]  alarm_out;
  logic [4:0]  dots;
  logic [64:0] q[$];
  logic [64:0] n;
  int          err_total, compares, v;
  int          xs[4] = '{50, -10, 300, 150};
  int          ys[4] = '{500, -100, -600, 600};
  int          tv[7][4] = '{'{32'h240, 3661, 10101, 20},
    '{32'h240, 45000, 1230, 4}, '{32'h240, 3600000, 1000, 0},
    '{32'h220, 90060, 101, 4}, '{32'h210, 12345, 12345, 16},
    '{32'h210, 12345678, 12345, 2}, '{32'h208, 12345, 123, 4}};
  logic [2:0]  ma[8] = '{AM_HON, AM_ON, AM_ON, AM_HOFF,
                         AM_NON, AM_NOFF, AM_OFF, AM_HOFF};

  mvp_postproc mvp_postproc_inst (.clk(clk), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(mval), .meas_value(mv), .meas_overflow(movf),
    .meas_ready(mrdy), .alarm_out(alarm_out), .disp_value(dv),
    .disp_dots(dots), .disp_overflow(dovf), .irq(irq));
  mvp_fe_model mvp_fe_model_inst (.clk(clk), .meas_ready(mrdy),
    .meas_valid(mval), .meas_value(mv), .meas_overflow(movf));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; a read notes its expectation for the monitor
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [31:0] m, logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) q.push_back({e, m, d});
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait out scan and divide, then the alarm/display edge
  task automatic meas(logic [31:0] x, logic o);
    mvp_fe_model_inst.send(x, o);
    @(posedge clk);
    while (mrdy !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // read data is judged at the edge that completes the access
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      n = q.pop_front();
      chk("prdata", prdata & n[63:32], n[31:0] & n[63:32]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, n[64]});
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    compares  = 0;
    void'($urandom(24));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // three points, first span stretched tenfold so the scan must step
    apb(1, OFS_DISP_PT + 12'h004, 32'h000003E8, 0, 0);
    apb(1, OFS_CTRL, 32'h00001F01, 0, 0);
    apb(0, OFS_CTRL, 32'h00001501, ALL, 0);
    apb(1, OFS_CTRL, 32'h00000301, 0, 0);
    for (int i = 0; i < 4; i++) begin
      meas(xs[i], 1'b0);
      apb(0, OFS_RESULT, ys[i], ALL, 0);
    end
    // unordered points fall back to pass-through
    apb(1, OFS_MEAS_PT + 12'h004, 32'h00000000, 0, 0);
    apb(1, OFS_IRQ_MASK, 32'h00000003, 0, 0);
    v = $urandom_range(99999);
    meas(v, 1'b0);
    apb(0, OFS_RESULT, v, ALL, 0);
    apb(0, OFS_STATUS, 32'h00000001, 32'h00000001, 0);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1, OFS_IRQ_STAT, 32'h0000003F, 0, 0);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1, OFS_IRQ_MASK, 32'h00000000, 0, 0);
    apb(1, OFS_ALM_LOW, 32'h7FFFFFFF, 0, 0);
    apb(0, OFS_ALM_LOW, VAL_MAX, ALL, 0);
    apb(1, OFS_ALM_LOW, 32'h80000000, 0, 0);
    apb(0, OFS_ALM_LOW, VAL_MIN, ALL, 0);
    apb(0, 12'hFFC, 32'h00000000, ALL, 1);
    apb(1, OFS_CTRL, 32'h00000200, 0, 0);
    // alarm 2 gets low above high on the first pass
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 4; a++) begin
        apb(1, OFS_ALM_LOW + 12'(4 * a), (p == 0 && a == 2) ? 5000 : 0, 0, 0);
        apb(1, OFS_ALM_HIGH + 12'(4 * a), (p == 0 && a == 2) ? 0 : 5000, 0, 0);
        apb(1, OFS_ALM_MODE + 12'(4 * a), 32'(ma[4 * p + a]), 0, 0);
      end
      meas(p ? 9000 : 100, p == 0);
      chk("alarm", 32'(alarm_out), p ? 32'h5 : 32'h3);
      chk("disp_overflow", {31'h0, dovf}, p ? 32'h0 : 32'h1);
    end
    // time modes and automatic decimals
    for (int i = 0; i < 7; i++) begin
      apb(1, OFS_CTRL, tv[i][0], 0, 0);
      meas(tv[i][1], 1'b0);
      chk("disp_value", dv, tv[i][2]);
      chk("disp_dots", {27'h0, dots}, tv[i][3]);
      apb(0, OFS_DISP_VAL, tv[i][2], ALL, 0);
      apb(0, OFS_DISP_DOTS, tv[i][3], ALL, 0);
    end
    apb(1, OFS_CTRL, 32'h00000002, 0, 0);
    apb(0, OFS_CTRL, 32'h00000200, ALL, 0);
    for (int a = 0; a < 4; a++) begin
      apb(0, OFS_ALM_MODE + 12'(4 * a), 32'(AM_HOFF), ALL, 0);
      apb(0, OFS_ALM_LOW + 12'(4 * a), RST_LOW, ALL, 0);
      apb(0, OFS_ALM_HIGH + 12'(4 * a), RST_HIGH, ALL, 0);
    end
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
